// *** pkg/tcm_pkg.sv ***
// Constants, field layout and helper functions of the 16-bit timer output compare block.
// Contract
// - A counter write suppresses every compare match in the next timer cycle.
// - Writing counter equal to variable TOP skips that match; counter runs to 0xFFFF.
// - Compare output state keeps its value across waveform mode changes.
// - Output action field is unbuffered and governs the first match after its write.
// - System reset clears the compare output state to zero.
// - Nonzero action overrides port value; pin drives only when direction selects output.
// - Action zero leaves the compare output state unchanged on a match.
// - Output action field never touches the capture side.
// - In non-PWM modes a force strobe applies the configured action at once.
// - Mode field picks counting; action field picks only output behaviour.
// - Mode 0 always counts up, never clears on match, wraps 0xFFFF to 0x0000.
// - Normal mode sets overflow flag as counter becomes zero; only cleared elsewhere.
// - Clear-on-match mode sets overflow flag on the MAX to 0x0000 roll.
// - Modes 4 and 12 clear the counter after it matches TOP (A or capture).
// - Clear-on-match TOP sets flag A or the capture flag per TOP source.
// - TOP is unbuffered; a TOP below the counter waits for the wrap.
// - Toggle action on channel A in clear-on-match gives a square wave.
// - Toggle frequency is clock over twice prescale times one plus compare.
// - Comparator matches counter against each channel; flag sets next timer cycle.
// - Forced compare updates output only, no flag, no counter change.
package tcm_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int CW = 16;
	localparam logic [AW-1:0] OFS_CTRL = 8'h00;
	localparam logic [AW-1:0] OFS_FORCE = 8'h04;
	localparam logic [AW-1:0] OFS_COUNT = 8'h08;
	localparam logic [AW-1:0] OFS_CMPA = 8'h0c;
	localparam logic [AW-1:0] OFS_CMPB = 8'h10;
	localparam logic [AW-1:0] OFS_CAPT = 8'h14;
	localparam logic [AW-1:0] OFS_FLAGS = 8'h18;
	localparam logic [AW-1:0] OFS_STAT = 8'h1c;
	localparam int CTRL_W = 15;
	localparam int CTRL_MODE = 0;
	localparam int CTRL_ACT_A = 4;
	localparam int CTRL_ACT_B = 6;
	localparam int CTRL_DIR_A = 8;
	localparam int CTRL_DIR_B = 9;
	localparam int CTRL_PORT_A = 10;
	localparam int CTRL_PORT_B = 11;
	localparam int CTRL_CS = 12;
	localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0000;
	localparam int FLG_OVF = 0;
	localparam int FLG_CMPA = 1;
	localparam int FLG_CMPB = 2;
	localparam int FLG_CAPT = 3;
	localparam int FLG_W = 4;
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_CTC_A = 4'h4;
	localparam logic [3:0] MODE_CTC_CAP = 4'hc;
	localparam logic [3:0] MODE_FPWM_CAP = 4'he;
	localparam logic [3:0] MODE_FPWM_A = 4'hf;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [CW-1:0] CNT_MAX = 16'hffff;
	localparam logic [CW-1:0] CNT_BOTTOM = 16'h0000;
	localparam logic [CW-1:0] CNT_ONE = 16'h0001;

	// Only normal and the two clear-on-match modes are non-PWM.
	function automatic logic is_pwm(input logic [3:0] m);
		return (m != MODE_NORMAL) && (m != MODE_CTC_A) && (m != MODE_CTC_CAP);
	endfunction

	function automatic logic top_from_capt(input logic [3:0] m);
		return (m == MODE_CTC_CAP) || (m == MODE_FPWM_CAP);
	endfunction

	function automatic logic top_from_a(input logic [3:0] m);
		return (m == MODE_CTC_A) || (m == MODE_FPWM_A);
	endfunction
endpackage

// *** design/tcm_prescale.sv ***
// Timer tick generator that divides the system clock by the selected prescale factor.
`timescale 1ns/1ps
`default_nettype none
module tcm_prescale #(
	parameter int DIV_W = 10
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [2:0] sel,
	output logic tick
);
	import tcm_pkg::*;

	logic [DIV_W-1:0] div_ff;

	// Free divider; held at zero while stopped so every start is aligned.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_ff <= '0;
		end else if (sel == CS_STOP) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end

	// One tick per full run of the low bits; unused codes keep the timer stopped.
	always_comb begin
		unique case (sel)
			CS_DIV1: tick = 1'b1;
			CS_DIV8: tick = &div_ff[2:0];
			CS_DIV64: tick = &div_ff[5:0];
			CS_DIV256: tick = &div_ff[7:0];
			CS_DIV1024: tick = &div_ff[9:0];
			default: tick = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// *** design/tcm_out_unit.sv ***
// Compare output unit of one channel: output state register and pin override.
`timescale 1ns/1ps
`default_nettype none
module tcm_out_unit (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic tick,
	input wire logic match,
	input wire logic force_cmp,
	input wire logic pwm,
	input wire logic [1:0] action,
	input wire logic dir,
	input wire logic port_val,
	output logic state,
	output logic pin_out,
	output logic pin_oe_n
);
	import tcm_pkg::*;

	logic oc_ff;
	logic act_now;

	// A real match acts on a tick and a force acts at once, both only outside PWM.
	assign act_now = (tick & match & ~pwm) | (force_cmp & ~pwm);

	// The state ignores mode changes, so it survives switching modes.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			oc_ff <= 1'b0;
		end else if (act_now) begin
			unique case (action)
				ACT_NONE: oc_ff <= oc_ff;
				ACT_TOGGLE: oc_ff <= ~oc_ff;
				ACT_CLEAR: oc_ff <= 1'b0;
				ACT_SET: oc_ff <= 1'b1;
			endcase
		end
	end

	assign state = oc_ff;
	// Any nonzero action steals the pin from the port; direction stays software's.
	assign pin_out = (action != ACT_NONE) ? oc_ff : port_val;
	assign pin_oe_n = ~dir;
endmodule
`default_nettype wire

// *** design/tcm_timer16_compare.sv ***
// Top of the 16-bit timer output compare block with its APB register slave.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module tcm_timer16_compare (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tcm_pkg::AW-1:0] paddr,
	input wire logic [tcm_pkg::DW-1:0] pwdata,
	output logic [tcm_pkg::DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic wave_a_out,
	output logic wave_a_oe_n,
	output logic wave_b_out,
	output logic wave_b_oe_n
);
	import tcm_pkg::*;

	logic [CTRL_W-1:0] ctrl_ff;
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] cmpa_ff;
	logic [CW-1:0] cmpb_ff;
	logic [CW-1:0] capt_ff;
	logic [FLG_W-1:0] flags_ff;
	logic [DW-1:0] prdata_ff;
	logic block_ff;

	logic [3:0] mode;
	logic [1:0] act_a;
	logic [1:0] act_b;
	logic [2:0] clk_sel;
	logic pwm;
	logic tick;
	logic wr_en;
	logic rd_setup;
	logic mapped;
	logic wr_cnt;
	logic [1:0] frc;
	logic [FLG_W-1:0] clr;
	logic [FLG_W-1:0] set;
	logic top_mode;
	logic [CW-1:0] top_val;
	logic match_a;
	logic match_b;
	logic match_top;
	logic oc_a;
	logic oc_b;
	logic [DW-1:0] rd_mux;

	// Control fields are read live, so a new action field governs the next match.
	assign mode = ctrl_ff[CTRL_MODE +: 4];
	assign act_a = ctrl_ff[CTRL_ACT_A +: 2];
	assign act_b = ctrl_ff[CTRL_ACT_B +: 2];
	assign clk_sel = ctrl_ff[CTRL_CS +: 3];
	assign pwm = is_pwm(mode);

	// APB decode; the slave never waits and flags unmapped words as errors.
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign prdata = prdata_ff;
	always_comb begin
		unique case (paddr)
			OFS_CTRL, OFS_FORCE, OFS_COUNT, OFS_CMPA: mapped = 1'b1;
			OFS_CMPB, OFS_CAPT, OFS_FLAGS, OFS_STAT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~mapped;

	// Write strobes; a force is a one-shot write, never stored.
	assign wr_cnt = wr_en & (paddr == OFS_COUNT);
	assign frc = (wr_en && paddr == OFS_FORCE) ? pwdata[1:0] : 2'h0;
	assign clr = (wr_en && paddr == OFS_FLAGS) ? pwdata[FLG_W-1:0] : '0;

	// Prescaler tick gates all counting; register writes use every system edge.
	tcm_prescale #(
		.DIV_W(10)
	) u_presc (
		.clk(clk),
		.arst_n(arst_n),
		.sel(clk_sel),
		.tick(tick)
	);

	// Configuration registers written at the APB access edge.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_ff <= CTRL_RST;
			cmpa_ff <= CNT_BOTTOM;
			cmpb_ff <= CNT_BOTTOM;
			capt_ff <= CNT_BOTTOM;
		end else if (wr_en) begin
			if (paddr == OFS_CTRL) begin
				ctrl_ff <= pwdata[CTRL_W-1:0];
			end
			// Compare values are not buffered in these modes; TOP may drop below the count.
			if (paddr == OFS_CMPA) begin
				cmpa_ff <= pwdata[CW-1:0];
			end
			if (paddr == OFS_CMPB) begin
				cmpb_ff <= pwdata[CW-1:0];
			end
			if (paddr == OFS_CAPT) begin
				capt_ff <= pwdata[CW-1:0];
			end
		end
	end

	// Comparators; a pending block hides every match, TOP included.
	assign top_mode = top_from_a(mode) | top_from_capt(mode);
	assign top_val = top_from_capt(mode) ? capt_ff : cmpa_ff;
	assign match_a = (cnt_ff == cmpa_ff) & ~block_ff;
	assign match_b = (cnt_ff == cmpb_ff) & ~block_ff;
	assign match_top = top_mode & (cnt_ff == top_val) & ~block_ff;

	// The block lasts until the next tick, so it works while stopped too.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			block_ff <= 1'b0;
		end else if (wr_cnt) begin
			block_ff <= 1'b1;
		end else if (tick) begin
			block_ff <= 1'b0;
		end
	end

	// Counter: software write wins, else clear after TOP or count up with wrap.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= CNT_BOTTOM;
		end else if (wr_cnt) begin
			cnt_ff <= pwdata[CW-1:0];
		end else if (tick) begin
			if (match_top) begin
				cnt_ff <= CNT_BOTTOM;
			end else begin
				cnt_ff <= cnt_ff + CNT_ONE;
			end
		end
	end

	// Flag sources, all taken on a tick; forces never reach here.
	always_comb begin
		set = '0;
		set[FLG_OVF] = tick & (cnt_ff == CNT_MAX) & ~wr_cnt;
		set[FLG_CMPA] = tick & match_a;
		set[FLG_CMPB] = tick & match_b;
		set[FLG_CAPT] = tick & match_top & top_from_capt(mode);
	end

	// Write-one-to-clear, and a set in the same cycle beats the clear.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= (flags_ff & ~clr) | set;
		end
	end

	// Channel A; a toggle with compare zero in mode 4 halves the tick rate.
	tcm_out_unit u_out_a (
		.clk(clk),
		.arst_n(arst_n),
		.tick(tick),
		.match(match_a),
		.force_cmp(frc[0]),
		.pwm(pwm),
		.action(act_a),
		.dir(ctrl_ff[CTRL_DIR_A]),
		.port_val(ctrl_ff[CTRL_PORT_A]),
		.state(oc_a),
		.pin_out(wave_a_out),
		.pin_oe_n(wave_a_oe_n)
	);

	// Channel B runs from the same counter with its own settings.
	tcm_out_unit u_out_b (
		.clk(clk),
		.arst_n(arst_n),
		.tick(tick),
		.match(match_b),
		.force_cmp(frc[1]),
		.pwm(pwm),
		.action(act_b),
		.dir(ctrl_ff[CTRL_DIR_B]),
		.port_val(ctrl_ff[CTRL_PORT_B]),
		.state(oc_b),
		.pin_out(wave_b_out),
		.pin_oe_n(wave_b_oe_n)
	);

	// Read mux; there is no capture unit here, so actions cannot affect one.
	always_comb begin
		rd_mux = '0;
		unique case (paddr)
			OFS_CTRL: rd_mux[CTRL_W-1:0] = ctrl_ff;
			OFS_COUNT: rd_mux[CW-1:0] = cnt_ff;
			OFS_CMPA: rd_mux[CW-1:0] = cmpa_ff;
			OFS_CMPB: rd_mux[CW-1:0] = cmpb_ff;
			OFS_CAPT: rd_mux[CW-1:0] = capt_ff;
			OFS_FLAGS: rd_mux[FLG_W-1:0] = flags_ff;
			OFS_STAT: rd_mux[1:0] = {oc_b, oc_a};
			default: rd_mux = '0;
		endcase
	end

	// Read data is captured in the setup cycle so prdata comes from a flop.
	// A flag that sets between setup and access shows on the next read.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata_ff <= '0;
		end else if (rd_setup) begin
			prdata_ff <= rd_mux;
		end
	end

	// Checks on the timer behaviour.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	property p_block;
		(block_ff && tick) |-> !set[FLG_CMPA] && !set[FLG_CMPB];
	endproperty
	a_block: assert property (p_block) else $error("match not blocked after counter write");

	property p_top_skip;
		(wr_cnt && top_mode && pwdata[CW-1:0] == top_val) ##1 (tick && !wr_cnt) |=>
			cnt_ff == $past(cnt_ff) + CNT_ONE;
	endproperty
	a_top_skip: assert property (p_top_skip) else $error("TOP match not skipped after write");

	property p_normal_cnt;
		(tick && !wr_cnt && mode == MODE_NORMAL && $stable(mode)) |=> cnt_ff == $past(cnt_ff) + CNT_ONE;
	endproperty
	a_normal_cnt: assert property (p_normal_cnt) else $error("normal mode did not count up");

	property p_ovf;
		(tick && !wr_cnt && cnt_ff == CNT_MAX && !pwm) |=> cnt_ff == CNT_BOTTOM && flags_ff[FLG_OVF];
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag not set on wrap");

	property p_ctc_clear;
		(tick && !wr_cnt && !block_ff && mode == MODE_CTC_A && cnt_ff == cmpa_ff) |=>
			cnt_ff == CNT_BOTTOM && flags_ff[FLG_CMPA];
	endproperty
	a_ctc_clear: assert property (p_ctc_clear) else $error("counter not cleared at TOP");

	property p_capt_flag;
		(tick && !wr_cnt && !block_ff && mode == MODE_CTC_CAP && cnt_ff == capt_ff) |=>
			flags_ff[FLG_CAPT] && cnt_ff == CNT_BOTTOM;
	endproperty
	a_capt_flag: assert property (p_capt_flag) else $error("capture flag not set at TOP");

	property p_flag_b;
		(tick && !block_ff && cnt_ff == cmpb_ff) |=> flags_ff[FLG_CMPB];
	endproperty
	a_flag_b: assert property (p_flag_b) else $error("flag B not set after match");

	property p_force_quiet;
		(frc != 2'h0 && !tick) |=> flags_ff == $past(flags_ff) && cnt_ff == $past(cnt_ff);
	endproperty
	a_force_quiet: assert property (p_force_quiet) else $error("force changed flags or counter");

	property p_force_toggle;
		(frc[0] && !pwm && act_a == ACT_TOGGLE) |=> oc_a != $past(oc_a);
	endproperty
	a_force_toggle: assert property (p_force_toggle) else $error("force did not toggle A");

	property p_no_action;
		(act_a == ACT_NONE && !frc[0]) ##1 (act_a == ACT_NONE) |-> $stable(oc_a);
	endproperty
	a_no_action: assert property (p_no_action) else $error("state A moved with action zero");

	property p_pin;
		(act_b != ACT_NONE) |-> wave_b_out == oc_b && wave_b_oe_n == !ctrl_ff[CTRL_DIR_B];
	endproperty
	a_pin: assert property (p_pin) else $error("pin B not overridden by state");

	property p_set_wins;
		(set[FLG_CMPA] && clr[FLG_CMPA]) |=> flags_ff[FLG_CMPA];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("flag set lost to clear");

	// The mode lands at the same edge as any action, so the quiet test looks one cycle back.
	property p_mode_keep;
		(!$stable(mode) && !$past(tick)) |-> $stable(oc_a);
	endproperty
	a_mode_keep: assert property (p_mode_keep) else $error("state A lost on mode change");

	property p_match_toggle;
		(tick && match_a && !pwm && act_a == ACT_TOGGLE) |=> oc_a != $past(oc_a);
	endproperty
	a_match_toggle: assert property (p_match_toggle) else $error("match did not toggle A");

	property p_match_set;
		(tick && match_a && !pwm && act_a == ACT_SET) |=> oc_a;
	endproperty
	a_match_set: assert property (p_match_set) else $error("match did not set A");

	property p_match_clear;
		(tick && match_a && !pwm && act_a == ACT_CLEAR) |=> !oc_a;
	endproperty
	a_match_clear: assert property (p_match_clear) else $error("match did not clear A");

	property p_pwm_force;
		(frc[0] && pwm) |=> oc_a == $past(oc_a);
	endproperty
	a_pwm_force: assert property (p_pwm_force) else $error("force acted in a PWM mode");

	property p_pin_port;
		(act_a == ACT_NONE) |-> wave_a_out == ctrl_ff[CTRL_PORT_A];
	endproperty
	a_pin_port: assert property (p_pin_port) else $error("pin A lost its port value");

	property p_cnt_write;
		wr_cnt |=> cnt_ff == CW'($past(pwdata));
	endproperty
	a_cnt_write: assert property (p_cnt_write) else $error("counter write did not land");

	property p_stopped;
		(clk_sel == CS_STOP && !wr_cnt) |=> cnt_ff == $past(cnt_ff);
	endproperty
	a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

	property p_cov_toggle;
		tick && mode == MODE_CTC_A && act_a == ACT_TOGGLE && match_a;
	endproperty
	c_cov_toggle: cover property (p_cov_toggle);

	property p_cov_ovf;
		set[FLG_OVF];
	endproperty
	c_cov_ovf: cover property (p_cov_ovf);

	property p_cov_force;
		frc[0] && !pwm && act_a == ACT_SET;
	endproperty
	c_cov_force: cover property (p_cov_force);

	property p_cov_block;
		block_ff && tick && cnt_ff == cmpa_ff;
	endproperty
	c_cov_block: cover property (p_cov_block);
endmodule
`default_nettype wire

// *** verification/tcm_wave_probe.sv ***
// Behavioural model of the load on one waveform pin: a pull-down and an edge timer.
`timescale 1ns/1ps
`default_nettype none
module tcm_wave_probe (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic drv,
	input wire logic drv_oe_n,
	output logic pin,
	output logic [31:0] edges,
	output logic [31:0] half_per
);
	logic last_ff;
	logic [31:0] since_ff;
	logic [31:0] edges_ff;
	logic [31:0] half_ff;
	// A released line falls to the pull-down level, so a stale drive never passes for a real one.
	assign pin = drv_oe_n ? 1'b0 : drv;
	assign edges = edges_ff;
	assign half_per = half_ff;
	// Clocks between pin edges give the half period that the toggle rate must show.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			last_ff <= 1'b0;
			since_ff <= '0;
			edges_ff <= '0;
			half_ff <= '0;
		end else if (pin != last_ff) begin
			last_ff <= pin;
			half_ff <= since_ff + 32'h1;
			since_ff <= '0;
			edges_ff <= edges_ff + 32'h1;
		end else begin
			since_ff <= since_ff + 32'h1;
		end
	end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench of the timer output compare block over its APB port and pins.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import tcm_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [AW-1:0] paddr = '0;
	logic [DW-1:0] pwdata = '0;
	logic [DW-1:0] prdata;
	logic pready, pslverr, wave_a_out, wave_a_oe_n, wave_b_out, wave_b_oe_n, pin_a, pin_b;
	logic [31:0] edges_a, half_a, v, k;
	logic [31:0] seed = 32'hacf2e68d;
	logic [32:0] exp_q[$];
	logic s;
	logic [1:0] acts[5] = '{ACT_SET, ACT_TOGGLE, ACT_NONE, ACT_CLEAR, ACT_TOGGLE};
	logic [3:0] t_mode[3] = '{MODE_NORMAL, MODE_CTC_A, MODE_CTC_CAP};
	logic [15:0] t_cnt[3] = '{16'hfff8, 16'hfff0, 16'h0000};
	logic [15:0] t_cmpa[3] = '{16'h0100, 16'h0005, 16'h0200};
	logic [15:0] t_capt[3] = '{16'h0100, 16'h0100, 16'h0003};
	logic [3:0] t_exp[3] = '{4'h1, 4'h3, 4'h8};
	logic [2:0] c_cs[5] = '{CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024};
	int c_div[5] = '{1, 8, 64, 256, 1024};
	int c_ocr[5] = '{0, 3, 1, 0, 0};
	int err_total = 0;
	int n_tests = 0;
	int n;

	// Free-running 20 MHz system clock.
	always #25 clk = ~clk;

	tcm_timer16_compare dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.wave_a_out(wave_a_out), .wave_a_oe_n(wave_a_oe_n), .wave_b_out(wave_b_out), .wave_b_oe_n(wave_b_oe_n));
	tcm_wave_probe probe_a (.clk(clk), .arst_n(arst_n), .drv(wave_a_out), .drv_oe_n(wave_a_oe_n), .pin(pin_a),
		.edges(edges_a), .half_per(half_a));
	tcm_wave_probe probe_b (.clk(clk), .arst_n(arst_n), .drv(wave_b_out), .drv_oe_n(wave_b_oe_n), .pin(pin_b),
		.edges(), .half_per());

	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("mismatches %0d in %0d checks", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] cfg(input logic [3:0] m, input logic [1:0] aa, input logic dir,
		input logic port, input logic [2:0] cs);
		return {17'h0, cs, 1'b0, port, 1'b0, dir, 2'b00, aa, m};
	endfunction

	// One APB transfer; the idle cycle at the end keeps a new setup off the release edge.
	task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		xfer(1'b1, a, d);
	endtask

	// A read only leaves a note; the watcher below does the comparing.
	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
		exp_q.push_back({a > OFS_STAT, e});
		xfer(1'b0, a, '0);
	endtask

	// Watcher: each completed read is matched against the oldest note, error flag included.
	always @(posedge clk) begin
		if (psel && penable && !pwrite && pready === 1'b1) begin
			chk({pslverr, prdata}, exp_q.size() > 0 ? exp_q.pop_front() : 33'bx);
		end
	end

	// Watchdog sized well beyond the few thousand cycles the sequence needs.
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		results();
	end

	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		chk({wave_a_oe_n, wave_b_oe_n, pin_a}, 3'b110);
		for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0);
		s = 1'b0;
		// Forced compares in normal mode while the pin is still an input.
		foreach (acts[i]) begin
			wr(OFS_CTRL, cfg(MODE_NORMAL, acts[i], 1'b0, 1'b0, CS_STOP));
			wr(OFS_FORCE, 32'h1);
			s = (acts[i] == ACT_SET) ? 1'b1 : (acts[i] == ACT_CLEAR) ? 1'b0 : (acts[i] == ACT_TOGGLE) ? ~s : s;
			rd(OFS_STAT, {31'h0, s});
		end
		rd(OFS_FLAGS, 32'h0);
		rd(OFS_COUNT, 32'h0);
		chk({wave_a_oe_n, pin_a}, 2'b10);
		wr(OFS_CTRL, cfg(MODE_NORMAL, ACT_SET, 1'b1, 1'b0, CS_STOP));
		chk({wave_a_oe_n, pin_a}, 2'b01);
		wr(OFS_CTRL, cfg(MODE_NORMAL, ACT_NONE, 1'b1, 1'b0, CS_STOP));
		chk(pin_a, 1'b0);
		wr(OFS_CTRL, cfg(MODE_CTC_A, ACT_NONE, 1'b0, 1'b0, CS_STOP));
		rd(OFS_STAT, 32'h1);
		wr(OFS_CTRL, 32'h40);
		wr(OFS_FORCE, 32'h2);
		rd(OFS_STAT, 32'h3);
		chk({wave_b_oe_n, pin_b}, 2'b10);
		wr(OFS_CTRL, cfg(MODE_FPWM_A, ACT_TOGGLE, 1'b0, 1'b0, CS_STOP));
		wr(OFS_FORCE, 32'h1);
		rd(OFS_STAT, 32'h3);
		wr(OFS_STAT, 32'h0);
		rd(OFS_STAT, 32'h3);
		wr(8'h20, 32'hff);
		rd(8'h20, 32'h0);
		repeat (4) begin
			v = rnd();
			wr(OFS_CMPB, v);
			wr(OFS_CAPT, {v[15:0], v[31:16]});
			rd(OFS_CMPB, {16'h0, v[15:0]});
			rd(OFS_CAPT, {16'h0, v[31:16]});
		end
		// A count loaded equal to a variable TOP skips that match and runs on upward.
		wr(OFS_CMPA, 32'h5);
		wr(OFS_COUNT, 32'h5);
		wr(OFS_CTRL, cfg(MODE_FPWM_A, ACT_NONE, 1'b0, 1'b0, CS_DIV1));
		wr(OFS_CTRL, cfg(MODE_FPWM_A, ACT_NONE, 1'b0, 1'b0, CS_STOP));
		rd(OFS_COUNT, 32'h8);
		// A count equal to compare A is loaded while stopped; B at 7 must still match.
		wr(OFS_CTRL, 32'h0);
		wr(OFS_FLAGS, 32'hf);
		wr(OFS_CMPA, 32'h5);
		wr(OFS_CMPB, 32'h7);
		wr(OFS_COUNT, 32'h5);
		wr(OFS_CTRL, cfg(MODE_NORMAL, ACT_NONE, 1'b0, 1'b0, CS_DIV1));
		repeat (6) @(posedge clk);
		wr(OFS_CTRL, 32'h0);
		rd(OFS_FLAGS, 32'h4);
		// Overflow and top-match flags in normal mode and both clear-on-match modes.
		for (int i = 0; i < 3; i++) begin
			wr(OFS_CTRL, cfg(t_mode[i], ACT_NONE, 1'b0, 1'b0, CS_STOP));
			wr(OFS_FLAGS, 32'hf);
			wr(OFS_CMPA, {16'h0, t_cmpa[i]});
			wr(OFS_CMPB, 32'h100);
			wr(OFS_CAPT, {16'h0, t_capt[i]});
			wr(OFS_COUNT, {16'h0, t_cnt[i]});
			wr(OFS_CTRL, cfg(t_mode[i], ACT_NONE, 1'b0, 1'b0, CS_DIV1));
			repeat (30) @(posedge clk);
			wr(OFS_CTRL, cfg(t_mode[i], ACT_NONE, 1'b0, 1'b0, CS_STOP));
			rd(OFS_FLAGS, {28'h0, t_exp[i]});
		end
		// Toggle output: half period is prescale times one plus the compare value.
		for (int i = 0; i < 5; i++) begin
			wr(OFS_CTRL, cfg(MODE_CTC_A, ACT_TOGGLE, 1'b1, 1'b0, CS_STOP));
			wr(OFS_CMPA, 32'(c_ocr[i]));
			// Start just below the wrap: a count equal to compare would lose its match to the write block.
			wr(OFS_COUNT, 32'hffff);
			wr(OFS_CTRL, cfg(MODE_CTC_A, ACT_TOGGLE, 1'b1, 1'b0, c_cs[i]));
			k = edges_a;
			n = 0;
			while (edges_a < k + 3 && n < 5000) begin
				@(posedge clk);
				n++;
			end
			chk(33'(n < 5000), 33'h1);
			chk(half_a, 33'(c_div[i] * (1 + c_ocr[i])));
		end
		// A new action while running governs the very next match.
		wr(OFS_CMPA, 32'h0);
		foreach (acts[i]) begin
			if (acts[i] == ACT_CLEAR || acts[i] == ACT_SET) begin
				wr(OFS_CTRL, cfg(MODE_CTC_A, acts[i], 1'b1, 1'b0, CS_DIV1));
				repeat (4) @(posedge clk);
				rd(OFS_STAT, {30'h0, 1'b1, acts[i] == ACT_SET});
				chk(pin_a, acts[i] == ACT_SET);
			end
		end
		wr(OFS_CTRL, 32'h0);
		results();
	end
endmodule
`default_nettype wire
